/* File: rtl/ts_insert_cfg.svh */
// Constants for the one-step timestamp insertion block
`ifndef TS_INSERT_CFG_SVH
`define TS_INSERT_CFG_SVH
`define OP_NONE_CODE      2'b00
`define OP_ONE_STEP_CODE  2'b01
`define OP_TWO_STEP_CODE  2'b10
`define OP_RSVD_CODE      2'b11
`define OFFSET_W          16
`define TIME_W            80
`define CORR_W            64
`define TAG_W             16
`define LANE_W            5
`define TS_BYTES          16'h000A
`define CORR_BYTES        16'h0008
`define CHK_BYTES         16'h0002
`define CHK_FILL          8'h00
`define LANE_STEP_NS      32'h00000001
`define QUEUE_AW          4
`define QUEUE_DW          96
`endif

/* File: rtl/ts_insert_pkg.sv */
// Types for the one-step timestamp insertion block
`include "ts_insert_cfg.svh"
package ts_insert_pkg;
  typedef enum logic [1:0] {
    OP_NONE     = `OP_NONE_CODE,
    OP_ONE_STEP = `OP_ONE_STEP_CODE,
    OP_TWO_STEP = `OP_TWO_STEP_CODE,
    OP_RSVD     = `OP_RSVD_CODE
  } op_t;
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_FRAME
  } frame_state_t;
  typedef logic [`QUEUE_DW-1:0] queue_word_t;
endpackage : ts_insert_pkg

/* File: rtl/tag_if.sv */
// Carrier between the controller and the tag queue memory
`timescale 1ns/1ns
interface tag_if;
  import ts_insert_pkg::*;
  logic        wr_en;
  queue_word_t wr_data;
  logic        rd_en;
  queue_word_t rd_data;
  logic        rd_valid;
  logic        full;
  logic        empty;
  modport ctrl  (output wr_en, output wr_data, output rd_en,
                 input rd_data, input rd_valid, input full, input empty);
  modport queue (input wr_en, input wr_data, input rd_en,
                 output rd_data, output rd_valid, output full, output empty);
endinterface : tag_if

/* File: rtl/tag_queue.sv */
// Tag and timestamp queue memory with registered read data
`timescale 1ns/1ns
`include "ts_insert_cfg.svh"
module tag_queue
  import ts_insert_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  tag_if.queue      q
);
  localparam int DEPTH = 1 << `QUEUE_AW;
  queue_word_t             mem_q [DEPTH];
  logic [`QUEUE_AW:0]      wr_ptr_q;
  logic [`QUEUE_AW:0]      rd_ptr_q;
  queue_word_t             rd_data_q;
  logic                    rd_valid_q;
  wire                     do_wr;
  wire                     do_rd;

  assign q.full     = (wr_ptr_q[`QUEUE_AW] != rd_ptr_q[`QUEUE_AW]) &&
                      (wr_ptr_q[`QUEUE_AW-1:0] == rd_ptr_q[`QUEUE_AW-1:0]);
  assign q.empty    = (wr_ptr_q == rd_ptr_q);
  assign do_wr      = q.wr_en && !q.full;
  assign do_rd      = q.rd_en && !q.empty;
  assign q.rd_data  = rd_data_q;
  assign q.rd_valid = rd_valid_q;

  always_ff @(posedge core_clk) begin
    if (ce && do_wr) begin
      mem_q[wr_ptr_q[`QUEUE_AW-1:0]] <= q.wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q   <= '0;
      rd_ptr_q   <= '0;
      rd_data_q  <= '0;
      rd_valid_q <= 1'b0;
    end else if (ce) begin
      rd_valid_q <= do_rd;
      if (do_wr) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_q  <= rd_ptr_q + 1'b1;
        rd_data_q <= mem_q[rd_ptr_q[`QUEUE_AW-1:0]];
      end
    end
  end
endmodule : tag_queue

/* File: rtl/tx_onestep_timestamp_insert.sv */
// Transmit one-step timestamp and correction insertion with tag queue
//
// Behaviour
// - Two-bit select: 00 none, 01 one-step insert, 10 two-step return, 11 reserved.
// - One-step with checksum flag set means a UDP checksum needs rework.
// - Checksum offset ignored unless one-step with checksum flag set.
// - Checksum offset counts bytes from first destination address byte.
// - One-step timestamp written at timestamp offset; ignored otherwise.
// - Timestamp offset also locates the correction field when updated.
// - Offsets are 16 bits, covering 16K-byte jumbo frames.
// - Lane adjust enable adds a per-lane correction to timestamps.
// - Lane correction applies to one-step only.
// - Sticky tag write fault, cleared only by reset.
// - Sticky tag read fault, cleared only by reset.
`timescale 1ns/1ns
`include "ts_insert_cfg.svh"
module tx_onestep_timestamp_insert
  import ts_insert_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic [`TIME_W-1:0]    system_time,
  input  wire logic [1:0]            timestamp_operation_select,
  input  wire logic                  update_checksum,
  input  wire logic                  correction_mode,
  input  wire logic [`OFFSET_W-1:0]  checksum_byte_offset,
  input  wire logic [`OFFSET_W-1:0]  timestamp_byte_offset,
  input  wire logic [`TAG_W-1:0]     tag_in,
  input  wire logic [`LANE_W-1:0]    sop_lane,
  input  wire logic                  lane_skew_adjust_enable,
  input  wire logic [63:0]           unused_receive_time_input,
  input  wire logic                  in_valid,
  input  wire logic [7:0]            in_data,
  input  wire logic                  in_last,
  output logic                       in_ready,
  output logic                       out_valid,
  output logic [7:0]                 out_data,
  output logic                       out_last,
  input  wire logic                  out_ready,
  input  wire logic                  tag_pop,
  output logic                       tag_out_valid,
  output logic [`TAG_W-1:0]          tag_out,
  output logic [`TIME_W-1:0]         timestamp_out,
  output logic                       tag_write_fault,
  output logic                       tag_read_fault
);
  function automatic logic is_op(input logic [1:0] sel, input op_t op);
    return sel == op;
  endfunction

  function automatic logic in_field(input logic [`OFFSET_W-1:0] pos,
                                    input logic [`OFFSET_W-1:0] base,
                                    input logic [`OFFSET_W-1:0] len);
    logic [`OFFSET_W-1:0] rel;
    rel = pos - base;
    return (pos >= base) && (rel < len);
  endfunction

  tag_if tq ();

  frame_state_t            state_q;
  frame_state_t            state_d;
  logic [`OFFSET_W-1:0]    byte_cnt_q;
  logic [1:0]              op_q;
  logic                    upd_q;
  logic                    corr_q;
  logic [`OFFSET_W-1:0]    chk_off_q;
  logic [`OFFSET_W-1:0]    ts_off_q;
  logic [`TIME_W-1:0]      ts_q;
  logic                    adj_meta_q;
  logic                    adj_sync_q;
  logic                    out_valid_q;
  logic [7:0]              out_data_q;
  logic                    out_last_q;
  logic                    wr_fault_q;
  logic                    rd_fault_q;

  wire                     accept;
  wire                     first;
  wire [1:0]               cur_op;
  wire                     cur_upd;
  wire                     cur_corr;
  wire [`OFFSET_W-1:0]     cur_chk;
  wire [`OFFSET_W-1:0]     cur_ts_off;
  wire [`TIME_W-1:0]       cur_ts;
  wire [`TIME_W-1:0]       adj_ts;
  wire [31:0]              lane_adj;
  wire                     one_step;
  wire                     two_step;
  wire                     chk_hit;
  wire                     ts_hit;
  wire [`OFFSET_W-1:0]     field_len;
  wire [`OFFSET_W-1:0]     rel;
  wire [7:0]               field_byte;
  wire [7:0]               ts_bytes   [`TS_BYTES];
  wire [7:0]               corr_bytes [`CORR_BYTES];
  wire [7:0]               new_byte;

  assign in_ready = out_ready || !out_valid_q;
  assign accept   = in_valid && in_ready;
  assign first    = (state_q == ST_IDLE);

  // Frame attributes come live on the first byte, held afterwards
  assign cur_op     = first ? timestamp_operation_select : op_q;
  assign cur_upd    = first ? update_checksum : upd_q;
  assign cur_corr   = first ? correction_mode : corr_q;
  assign cur_chk    = first ? checksum_byte_offset : chk_off_q;
  assign cur_ts_off = first ? timestamp_byte_offset : ts_off_q;

  assign one_step = is_op(cur_op, OP_ONE_STEP);
  assign two_step = is_op(cur_op, OP_TWO_STEP);

  // Per-lane correction on the nanosecond field
  assign lane_adj = 32'(sop_lane) * `LANE_STEP_NS;
  assign adj_ts   = {system_time[`TIME_W-1:32],
                     system_time[31:0] + lane_adj};
  assign cur_ts   = first ? ((adj_sync_q && one_step) ? adj_ts : system_time)
                          : ts_q;

  // Checksum position only honoured for one-step with rework requested
  assign chk_hit = one_step && cur_upd &&
                   in_field(byte_cnt_q, cur_chk, `CHK_BYTES);

  // Timestamp or correction field at the timestamp offset
  assign field_len = cur_corr ? `CORR_BYTES : `TS_BYTES;
  assign ts_hit    = one_step &&
                     in_field(byte_cnt_q, cur_ts_off, field_len);
  assign rel       = byte_cnt_q - cur_ts_off;

  genvar gi;
  generate
    for (gi = 0; gi < `TS_BYTES; gi++) begin : g_ts_bytes
      assign ts_bytes[gi] = cur_ts[`TIME_W-1-8*gi -: 8];
    end
    for (gi = 0; gi < `CORR_BYTES; gi++) begin : g_corr_bytes
      assign corr_bytes[gi] = cur_ts[`CORR_W-1-8*gi -: 8];
    end
  endgenerate

  assign field_byte = cur_corr ? corr_bytes[rel[2:0]] : ts_bytes[rel[3:0]];
  assign new_byte   = ts_hit  ? field_byte :
                      chk_hit ? `CHK_FILL : in_data;

  // Frame tracking
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (accept && !in_last) begin
          state_d = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (accept && in_last) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      byte_cnt_q <= '0;
    end else if (ce && accept) begin
      state_q    <= state_d;
      byte_cnt_q <= in_last ? '0 : byte_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q      <= `OP_NONE_CODE;
      upd_q     <= 1'b0;
      corr_q    <= 1'b0;
      chk_off_q <= '0;
      ts_off_q  <= '0;
      ts_q      <= '0;
    end else if (ce && accept && first) begin
      op_q      <= timestamp_operation_select;
      upd_q     <= update_checksum;
      corr_q    <= correction_mode;
      chk_off_q <= checksum_byte_offset;
      ts_off_q  <= timestamp_byte_offset;
      ts_q      <= cur_ts;
    end
  end

  // Two-stage synchroniser for the quasi-static enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      adj_meta_q <= 1'b0;
      adj_sync_q <= 1'b0;
    end else if (ce) begin
      adj_meta_q <= lane_skew_adjust_enable;
      adj_sync_q <= adj_meta_q;
    end
  end

  // Output stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_q <= 1'b0;
      out_data_q  <= 8'h00;
      out_last_q  <= 1'b0;
    end else if (ce && in_ready) begin
      out_valid_q <= in_valid;
      if (in_valid) begin
        out_data_q <= new_byte;
        out_last_q <= in_last;
      end
    end
  end

  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;
  assign out_last  = out_last_q;

  // Tag queue for one-step and two-step frames
  assign tq.wr_en   = ce && accept && first && (one_step || two_step);
  assign tq.wr_data = {tag_in, cur_ts};
  assign tq.rd_en   = ce && tag_pop;

  tag_queue u_tag_queue (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .q        (tq.queue)
  );

  assign tag_out_valid = tq.rd_valid;
  assign tag_out       = tq.rd_data[`QUEUE_DW-1 -: `TAG_W];
  assign timestamp_out = tq.rd_data[`TIME_W-1:0];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_fault_q <= 1'b0;
      rd_fault_q <= 1'b0;
    end else if (ce) begin
      if (tq.wr_en && tq.full) begin
        wr_fault_q <= 1'b1;
      end
      if (tq.rd_en && tq.empty) begin
        rd_fault_q <= 1'b1;
      end
    end
  end

  assign tag_write_fault = wr_fault_q;
  assign tag_read_fault  = rd_fault_q;
endmodule : tx_onestep_timestamp_insert

/* File: dv/ts_insert_asserts.sv */
// Port checker for the timestamp insertion block
`timescale 1ns/1ns
module ts_insert_asserts (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       ce,
  input wire logic [1:0] timestamp_operation_select,
  input wire logic       tag_pop,
  input wire logic       in_valid,
  input wire logic [7:0] in_data,
  input wire logic       in_last,
  input wire logic       in_ready,
  input wire logic       out_valid,
  input wire logic [7:0] out_data,
  input wire logic       out_last,
  input wire logic       out_ready,
  input wire logic       tag_out_valid,
  input wire logic       tag_write_fault,
  input wire logic       tag_read_fault
);
  logic       first_q;
  logic [1:0] op_q;
  wire        take   = ce && in_valid && in_ready;
  wire  [1:0] cur_op = first_q ? timestamp_operation_select : op_q;
  wire        push_w = take && first_q && cur_op inside {2'b01, 2'b10};
  wire        pop_w  = ce && tag_pop;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_q <= 1'b1;
      op_q    <= 2'b00;
    end else if (take) begin
      first_q <= in_last;
      op_q    <= cur_op;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_plain;
    take && cur_op != 2'b01;
  endsequence
  sequence s_end;
    take && in_last;
  endsequence
  chk_plain_pass: assert property (s_plain |=> out_valid && out_data == $past(in_data))
    else $error("unmodified byte changed");
  chk_stall_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data) && $stable(out_last))
    else $error("stalled output moved");
  chk_ready_refuse: assert property (out_valid && !out_ready |-> !in_ready)
    else $error("input taken while output stalled");
  chk_last_mark: assert property (s_end |=> out_valid && out_last)
    else $error("frame end not marked");
  chk_wfault_hold: assert property (tag_write_fault |=> tag_write_fault)
    else $error("write fault dropped");
  chk_wfault_cause: assert property ($rose(tag_write_fault) |->
    $past(push_w) || $past(push_w, 2))
    else $error("write fault without push");
  chk_rfault_hold: assert property (tag_read_fault |=> tag_read_fault)
    else $error("read fault dropped");
  chk_rfault_cause: assert property ($rose(tag_read_fault) |->
    $past(pop_w) || $past(pop_w, 2))
    else $error("read fault without pop");
  chk_pop_answer: assert property (tag_out_valid |-> $past(pop_w))
    else $error("tag valid without pop");
endmodule // ts_insert_asserts
bind tx_onestep_timestamp_insert ts_insert_asserts u_asserts (.core_clk, .rst_n, .ce,
  .timestamp_operation_select, .tag_pop, .in_valid, .in_data, .in_last, .in_ready,
  .out_valid, .out_data, .out_last, .out_ready, .tag_out_valid, .tag_write_fault,
  .tag_read_fault);

/* File: dv/client_tx_model.sv */
// Client transmit model supplying byte frames
`timescale 1ns/1ns
module client_tx_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [15:0] len,
  input  wire logic        in_ready,
  output logic             in_valid,
  output logic [7:0]       in_data,
  output logic             in_last
);
  logic [15:0] cnt_q;
  // Byte held until taken; idle data inverted
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_valid <= 1'b0;
      in_data  <= 8'h00;
      in_last  <= 1'b0;
      cnt_q    <= 16'h0000;
    end else if (start && !in_valid) begin
      in_valid <= 1'b1;
      in_data  <= 8'hA5;
      in_last  <= (len == 16'h0001);
      cnt_q    <= 16'h0000;
    end else if (in_valid && in_ready) begin
      if (in_last) begin
        in_valid <= 1'b0;
        in_data  <= ~in_data;
        in_last  <= 1'b0;
      end else begin
        in_data  <= (cnt_q[7:0] + 8'h01) ^ 8'hA5;
        in_last  <= (cnt_q + 16'h0002 == len);
        cnt_q    <= cnt_q + 16'h0001;
      end
    end
  end
endmodule // client_tx_model

/* File: dv/tx_onestep_timestamp_insert_test.sv */
// Self-checking bench for the timestamp insertion block
`timescale 1ns/1ns
module tx_onestep_timestamp_insert_test;
  import ts_insert_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, out_ready = 1'b1, tag_pop = 1'b0, le = 1'b0;
  logic upd = 1'b0, cm = 1'b0, start = 1'b0, in_valid, in_last, in_ready;
  logic out_valid, out_last, tov, wf, rf;
  logic [1:0]  op = 2'b00;
  logic [15:0] cko = '0, tso = '0, tg = '0, len = 16'h0010, mi = '0, l, tag_out;
  logic [4:0]  ln = '0;
  logic [79:0] st = '0, ts_out;
  logic [7:0]  in_data, out_data;
  integer      seed = 32'hE507, err_total = 0, check_count = 0, n, k;
  always #2 core_clk = ~core_clk;
  tx_onestep_timestamp_insert u_dut (.core_clk, .rst_n, .ce(1'b1), .system_time(st),
    .timestamp_operation_select(op), .update_checksum(upd), .correction_mode(cm),
    .checksum_byte_offset(cko), .timestamp_byte_offset(tso), .tag_in(tg), .sop_lane(ln),
    .lane_skew_adjust_enable(le), .unused_receive_time_input(64'h0), .in_valid,
    .in_data, .in_last, .in_ready, .out_valid, .out_data, .out_last, .out_ready, .tag_pop,
    .tag_out_valid(tov), .tag_out, .timestamp_out(ts_out), .tag_write_fault(wf),
    .tag_read_fault(rf));
  client_tx_model u_client (.core_clk, .rst_n, .start, .len, .in_ready, .in_valid,
    .in_data, .in_last);
  function automatic logic [79:0] adj_time();
    adj_time = st;
    if (le && op == 2'b01) adj_time[31:0] = st[31:0] + 32'(ln);
  endfunction
  function automatic logic [7:0] exp_byte(input logic [15:0] i);
    logic [79:0] f;
    f = cm ? {16'h0000, st[63:0]} : adj_time();
    exp_byte = i[7:0] ^ 8'hA5;
    if (op == 2'b01 && upd && i >= cko && i < cko + 16'h0002) exp_byte = 8'h00;
    if (op == 2'b01 && i >= tso && i < tso + (cm ? 16'h0008 : 16'h000A))
      exp_byte = f[8 * ((cm ? 16'h0007 : 16'h0009) - (i - tso)) +: 8];
  endfunction
  task automatic compare(input string what, input logic [79:0] e, input logic [79:0] s);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) if (rst_n && out_valid && out_ready) begin
    compare("out_data", exp_byte(mi), out_data);
    compare("out_last", mi == len - 16'h0001, out_last);
    mi = out_last ? 16'h0000 : mi + 16'h0001;
  end
  task automatic send();
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    for (k = 0; k < 40000 && !(out_valid && out_ready && out_last); k++) begin
      out_ready <= ($random(seed) % 3) != 0;
      @(posedge core_clk);
    end
    if (k == 40000) begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic pop(input logic ev, input logic [15:0] et, input logic [79:0] ets);
    tag_pop <= 1'b1;
    @(posedge core_clk);
    tag_pop <= 1'b0;
    @(posedge core_clk);
    compare("tag_out_valid", ev, tov);
    if (ev) compare("tag_out", et, tag_out);
    if (ev) compare("timestamp_out", ets, ts_out);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    pop(1'b0, 16'h0000, 80'h0);
    compare("read_fault", 1'b1, rf);
    for (n = 0; n < 26; n++) begin
      if (n == 12) le <= 1'b1;
      repeat (4) @(posedge core_clk);
      l = 16'h0018 + 16'($unsigned($random(seed)) % 20);
      op <= 2'(n);
      upd <= 1'($random(seed));
      cm <= n % 8 > 4;
      ln <= (n % 8 > 4) ? 5'h00 : 5'($random(seed));
      st <= {$random(seed), $random(seed), 16'($random(seed))};
      tg <= 16'($random(seed));
      len <= l;
      tso <= (n % 12 == 1) ? 16'h0000 : 16'($unsigned($random(seed)) % (l - 16'h000A));
      cko <= (n % 12 == 1) ? 16'h0004 :
             16'($unsigned($random(seed)) % (l - 16'h0002)) & 16'hFFFE;
      if (n == 24) begin
        op <= 2'b01;
        upd <= 1'b1;
        cm <= 1'b0;
        len <= 16'h3FFC;
        tso <= 16'h3FF0;
        cko <= 16'h3FFA;
      end
      send();
      if (op == 2'b01 || op == 2'b10) pop(1'b1, tg, op == 2'b01 ? adj_time() : st);
    end
    op <= 2'b10;
    len <= 16'h0010;
    for (n = 0; n < 17; n++) send();
    compare("write_fault", 1'b1, wf);
    compare("read_fault", 1'b1, rf);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    compare("write_fault", 1'b0, wf);
    compare("read_fault", 1'b0, rf);
    report_and_stop();
  end
endmodule // tx_onestep_timestamp_insert_test
